// File: core/pmq_pkg.sv
package pmq_pkg;

  // Data path: 36-bit words, markers in the two top bits
  localparam int DATA_W = 36;
  localparam int START_BIT = 34;
  localparam int END_BIT = 35;

  // Queue geometry defaults
  localparam int NUM_QUEUES = 16;
  localparam int QUEUE_DEPTH = 16;
  localparam int BUS_QUEUES = 8;

  // Register map of the AXI4-Lite slave (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_READY = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_SECTOR_BIT = 0;
  localparam int STATUS_WQ_LSB = 0;
  localparam int STATUS_RQ_LSB = 4;
  localparam int STATUS_PKT_BIT = 8;
  localparam int STATUS_STYLE_BIT = 9;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pmq_pkg

// File: core/pmq_mem.sv
`timescale 1ns/1ps
// Simple dual-port word store with registered read data
module pmq_mem #(
  parameter int W = 36,
  parameter int AW = 8
) (
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);

  logic [W-1:0] mem_reg [2**AW];

  // Write port
  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem_reg[i_waddr] <= i_wdata;
    end
  end

  // Read port, data valid the cycle after the request
  always_ff @(posedge i_clk) begin
    if (i_ce && i_re) begin
      o_rdata <= mem_reg[i_raddr];
    end
  end

endmodule : pmq_mem

// File: core/pmq_switch.sv
`timescale 1ns/1ps
// Function
// - Write queue change takes two cycles
// - Request cycle write still lands in old queue
// - Full flag follows new queue next edge
// - Third edge writes new queue unless full
// - Read queue change takes two cycles
// - Request cycle read needs enable and drive
// - Filler falls through, then new queue
// - Packet mode strapped high at reset
// - Ready flag shows selected read queue
// - Ready flag high without full packet
// - Nothing but switch-cycle filler output before complete packet
// - Flag bus shows eight queues, style strapped
// - Both data buses are 36 bits
// - Bits 34, 35 mark start, end
// - Marker stored with its word
// - Per-queue packet counter watches markers
// - Last packet start out raises ready
// - Repeated start or end markers ignored
module pmq_switch
  import pmq_pkg::*;
#(
  parameter int NQ = NUM_QUEUES,
  parameter int DEPTH = QUEUE_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_packet_mode_select,
  input wire logic i_flag_bus_style,
  input wire logic i_write_queue_select_strobe,
  input wire logic [$clog2(NQ)-1:0] i_write_queue_address,
  input wire logic i_write_enable_n,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic o_full_flag_n,
  input wire logic i_read_queue_select_strobe,
  input wire logic [$clog2(NQ)-1:0] i_read_queue_address,
  input wire logic i_read_enable_n,
  input wire logic i_output_drive_enable_n,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_rx_start_marker,
  output logic o_rx_end_marker,
  output logic o_output_valid_n,
  output logic o_packet_ready_n,
  output logic [BUS_QUEUES-1:0] o_packet_ready_bus,
  output logic o_flag_bus_sector,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [31:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp
);

  localparam int QW = $clog2(NQ);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  // Queue is full when its word count reaches the depth
  function automatic logic is_full(input logic [CW-1:0] cnt);
    return cnt == FULL_COUNT;
  endfunction : is_full

  ////////////////////////////////////////////////////////////////////////////
  // Straps, caught once after reset release
  logic init_done_reg;
  logic pkt_mode_reg;
  logic style_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_done_reg <= 1'b0;
      pkt_mode_reg <= 1'b0;
      style_reg <= 1'b0;
    end else if (i_ce && !init_done_reg) begin
      init_done_reg <= 1'b1;
      pkt_mode_reg <= i_packet_mode_select;
      style_reg <= i_flag_bus_style;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-queue state
  logic [PW-1:0] wptr_reg [NQ];
  logic [PW-1:0] rptr_reg [NQ];
  logic [CW-1:0] cnt_reg [NQ];
  logic [CW-1:0] pkt_reg [NQ];
  logic [NQ-1:0] win_reg;
  logic [NQ-1:0] rin_reg;
  logic [NQ-1:0] ready_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Write port queue selection
  logic [QW-1:0] wq_reg;
  logic [QW-1:0] wpend_reg;
  logic wsw_reg;
  logic wr_do;

  // capture next write queue, switch one edge later
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wq_reg <= '0;
      wpend_reg <= '0;
      wsw_reg <= 1'b0;
    end else if (i_ce) begin
      if (wsw_reg) begin
        wq_reg <= wpend_reg;
        wsw_reg <= 1'b0;
      end else if (i_write_queue_select_strobe) begin
        wpend_reg <= i_write_queue_address;
        wsw_reg <= 1'b1;
      end
    end
  end

  // old queue takes request and filler cycles
  assign wr_do = init_done_reg && !i_write_enable_n && !is_full(cnt_reg[wq_reg]);

  // flag follows queue that takes the write
  assign o_full_flag_n = !is_full(cnt_reg[wq_reg]);

  ////////////////////////////////////////////////////////////////////////////
  // Read port queue selection and output stage
  logic [QW-1:0] rq_reg;
  logic [QW-1:0] rpend_reg;
  logic rsw_reg;
  logic ov_reg;
  logic pend_reg;
  logic [QW-1:0] lq_reg;
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W-1:0] rdata_reg;
  logic take;
  logic eligible;
  logic pop;
  logic ld_start;
  logic ld_end;

  // capture read queue, switch one edge later
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rq_reg <= '0;
      rpend_reg <= '0;
      rsw_reg <= 1'b0;
    end else if (i_ce) begin
      if (rsw_reg) begin
        rq_reg <= rpend_reg;
        rsw_reg <= 1'b0;
      end else if (i_read_queue_select_strobe) begin
        rpend_reg <= i_read_queue_address;
        rsw_reg <= 1'b1;
      end
    end
  end

  // request-cycle read needs both enables low
  assign take = ov_reg && !i_read_enable_n
    && (!i_read_queue_select_strobe || !i_output_drive_enable_n);

  // switch cycle lets old filler fall through
  // otherwise a packet must be complete or open
  assign eligible = (cnt_reg[rq_reg] != '0) && (!pkt_mode_reg || rsw_reg
    || rin_reg[rq_reg] || (pkt_reg[rq_reg] != '0));
  assign pop = init_done_reg && eligible && !pend_reg && (!ov_reg || take);

  // Output register loads the fetched word, valid drops on a take
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ov_reg <= 1'b0;
      pend_reg <= 1'b0;
      lq_reg <= '0;
      rdata_reg <= '0;
    end else if (i_ce) begin
      pend_reg <= pop;
      lq_reg <= rq_reg;
      if (pend_reg) begin
        rdata_reg <= mem_rdata;
        ov_reg <= 1'b1;
      end else if (take) begin
        ov_reg <= 1'b0;
      end
    end
  end

  // markers leave on bits 34 and 35
  assign o_rdata = rdata_reg;
  assign o_rx_start_marker = rdata_reg[START_BIT];
  assign o_rx_end_marker = rdata_reg[END_BIT];
  assign o_output_valid_n = !ov_reg;
  assign ld_start = pend_reg && pkt_mode_reg && mem_rdata[START_BIT];
  assign ld_end = pend_reg && pkt_mode_reg && mem_rdata[END_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // whole 36-bit word with markers stored together
  pmq_mem #(
    .W(DATA_W),
    .AW(QW + PW)
  ) u_mem (
    .i_clk(i_clk),
    .i_ce(i_ce),
    .i_we(wr_do),
    .i_waddr({wq_reg, wptr_reg[wq_reg]}),
    .i_wdata(i_wdata),
    .i_re(pop),
    .i_raddr({rq_reg, rptr_reg[rq_reg]}),
    .o_rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pointers, word counts, packet tracking
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NQ; i++) begin
        wptr_reg[i] <= '0;
        rptr_reg[i] <= '0;
        cnt_reg[i] <= '0;
        pkt_reg[i] <= '0;
      end
      win_reg <= '0;
      rin_reg <= '0;
    end else if (i_ce) begin
      for (int i = 0; i < NQ; i++) begin
        logic inc_w;
        logic dec_w;
        logic inc_p;
        logic dec_p;
        inc_w = wr_do && (wq_reg == QW'(i));
        dec_w = pop && (rq_reg == QW'(i));
        // end counts only inside an open packet
        inc_p = inc_w && pkt_mode_reg && i_wdata[END_BIT] && win_reg[i];
        // first start out consumes the packet
        dec_p = ld_start && (lq_reg == QW'(i)) && !rin_reg[i];
        if (inc_w) begin
          wptr_reg[i] <= wptr_reg[i] + PW'(1);
        end
        if (dec_w) begin
          rptr_reg[i] <= rptr_reg[i] + PW'(1);
        end
        if (inc_w && !dec_w) begin
          cnt_reg[i] <= cnt_reg[i] + CW'(1);
        end else if (dec_w && !inc_w) begin
          cnt_reg[i] <= cnt_reg[i] - CW'(1);
        end
        if (inc_p && !dec_p) begin
          pkt_reg[i] <= pkt_reg[i] + CW'(1);
        end else if (dec_p && !inc_p) begin
          pkt_reg[i] <= pkt_reg[i] - CW'(1);
        end
        // second start ignored on write side
        if (inc_w && pkt_mode_reg) begin
          if (!win_reg[i] && i_wdata[START_BIT]) begin
            win_reg[i] <= 1'b1;
          end else if (win_reg[i] && i_wdata[END_BIT]) begin
            win_reg[i] <= 1'b0;
          end
        end
        // second start ignored on read side
        if (lq_reg == QW'(i)) begin
          if (!rin_reg[i] && ld_start) begin
            rin_reg[i] <= 1'b1;
          end else if (rin_reg[i] && ld_end) begin
            rin_reg[i] <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet ready flag and flag bus
  logic [31:0] ctrl_reg;
  logic poll_sector_reg;
  logic sector;

  // ready only with a whole packet counted
  always_comb begin
    for (int i = 0; i < NQ; i++) begin
      ready_vec[i] = pkt_mode_reg && (pkt_reg[i] != '0);
    end
  end

  // discrete flag shows the read queue
  assign o_packet_ready_n = !ready_vec[rq_reg];

  // Polled style walks the sectors, one per clock
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      poll_sector_reg <= 1'b0;
    end else if (i_ce && style_reg && NQ > BUS_QUEUES) begin
      poll_sector_reg <= !poll_sector_reg;
    end
  end

  // eight queues per sector, style picks source
  assign sector = style_reg ? poll_sector_reg : ctrl_reg[CTRL_SECTOR_BIT];
  assign o_flag_bus_sector = sector;
  always_comb begin
    for (int b = 0; b < BUS_QUEUES; b++) begin
      if (sector && (b + BUS_QUEUES < NQ)) begin
        o_packet_ready_bus[b] = !ready_vec[b + BUS_QUEUES];
      end else if (!sector && b < NQ) begin
        o_packet_ready_bus[b] = !ready_vec[b];
      end else begin
        o_packet_ready_bus[b] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic aw_got_reg;
  logic w_got_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  assign o_axi_awready = !aw_got_reg && !o_axi_bvalid;
  assign o_axi_wready = !w_got_reg && !o_axi_bvalid;
  assign o_axi_arready = !o_axi_rvalid;

  // Write channel: address and data in either order
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      o_axi_bvalid <= 1'b0;
      o_axi_bresp <= RESP_OKAY;
      ctrl_reg <= CTRL_RESET;
    end else if (i_ce) begin
      if (i_axi_awvalid && o_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= i_axi_awaddr[3:0];
      end
      if (i_axi_wvalid && o_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= i_axi_wdata;
        wstrb_reg <= i_axi_wstrb;
      end
      if (aw_got_reg && w_got_reg) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        o_axi_bvalid <= 1'b1;
        o_axi_bresp <= RESP_SLVERR;
        if (awaddr_reg == REG_CTRL) begin
          o_axi_bresp <= RESP_OKAY;
          for (int k = 0; k < 4; k++) begin
            if (wstrb_reg[k]) begin
              ctrl_reg[8*k +: 8] <= wdata_reg[8*k +: 8];
            end
          end
        end else if (awaddr_reg == REG_STATUS || awaddr_reg == REG_READY) begin
          o_axi_bresp <= RESP_OKAY;
        end
      end else if (o_axi_bvalid && i_axi_bready) begin
        o_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one-cycle answer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_axi_rvalid <= 1'b0;
      o_axi_rdata <= '0;
      o_axi_rresp <= RESP_OKAY;
    end else if (i_ce) begin
      if (i_axi_arvalid && o_axi_arready) begin
        o_axi_rvalid <= 1'b1;
        o_axi_rresp <= RESP_OKAY;
        o_axi_rdata <= '0;
        case (i_axi_araddr[3:0])
          REG_CTRL: begin
            o_axi_rdata <= ctrl_reg;
          end
          REG_STATUS: begin
            o_axi_rdata[STATUS_WQ_LSB +: QW] <= wq_reg;
            o_axi_rdata[STATUS_RQ_LSB +: QW] <= rq_reg;
            o_axi_rdata[STATUS_PKT_BIT] <= pkt_mode_reg;
            o_axi_rdata[STATUS_STYLE_BIT] <= style_reg;
          end
          REG_READY: begin
            o_axi_rdata[NQ-1:0] <= ready_vec;
          end
          default: begin
            o_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (o_axi_rvalid && i_axi_rready) begin
        o_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_wr_switch;
    @(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    (i_write_queue_select_strobe && !wsw_reg) |=> (wq_reg == $past(wq_reg))
      ##1 (wq_reg == $past(i_write_queue_address, 2));
  endproperty
  a_wr_switch: assert property (p_wr_switch) else $error("write queue switch timing");

  property p_full_flag;
    @(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    (i_write_queue_select_strobe && !wsw_reg) |=> ##1
      (o_full_flag_n == !is_full(cnt_reg[$past(i_write_queue_address, 2)]));
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag not on new queue");

  property p_no_full_write;
    @(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    (!i_write_enable_n && !o_full_flag_n && !(pop && rq_reg == wq_reg))
      |=> (cnt_reg[$past(wq_reg)] == FULL_COUNT);
  endproperty
  a_no_full_write: assert property (p_no_full_write) else $error("write into full queue");

  property p_rd_switch;
    @(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    (i_read_queue_select_strobe && !rsw_reg) |=> rsw_reg
      ##1 (rq_reg == $past(i_read_queue_address, 2));
  endproperty
  a_rd_switch: assert property (p_rd_switch) else $error("read queue switch timing");

  property p_rd_oe;
    @(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    (ov_reg && i_read_queue_select_strobe && i_output_drive_enable_n) |=> ov_reg;
  endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("read taken without drive enable");

  property p_hold_output;
    @(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    (pkt_mode_reg && !rsw_reg && !pend_reg && !ov_reg && !rin_reg[rq_reg]
      && pkt_reg[rq_reg] == '0) |=> ##1 !ov_reg;
  endproperty
  a_hold_output: assert property (p_hold_output) else $error("word out before packet");

  property p_last_start;
    @(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    (ld_start && lq_reg == rq_reg && !rsw_reg && !rin_reg[lq_reg]
      && pkt_reg[lq_reg] == CW'(1) && !wr_do) |=> (o_packet_ready_n && !o_output_valid_n);
  endproperty
  a_last_start: assert property (p_last_start) else $error("ready stays low on last start");

  property p_count_up;
    @(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    (wr_do && pkt_mode_reg && i_wdata[END_BIT] && win_reg[wq_reg] && !pend_reg)
      |=> (pkt_reg[$past(wq_reg)] == $past(pkt_reg[wq_reg]) + CW'(1));
  endproperty
  a_count_up: assert property (p_count_up) else $error("packet count missed an end");

  property p_strap;
    @(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    $rose(init_done_reg) |-> (pkt_mode_reg == $past(i_packet_mode_select));
  endproperty
  a_strap: assert property (p_strap) else $error("packet mode strap not caught");

endmodule : pmq_switch

// File: bench/pmq_host.sv
`timescale 1ns/1ps
// Host writer on the write port: queue changes with a filler, then whole packets
module pmq_host
  import pmq_pkg::*;
(
  input wire logic i_clk,
  output logic o_strobe,
  output logic [3:0] o_addr,
  output logic o_wen_n,
  output logic [DATA_W-1:0] o_wdata
);
  // Filler word carries no markers
  localparam logic [DATA_W-1:0] FILL = 36'h0_0000_0000;

  // Idle bus at time zero
  initial begin
    o_strobe = 1'b0;
    o_addr = 4'h0;
    o_wen_n = 1'b1;
    o_wdata = 36'hF_FFFF_FFFF;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // change with filler
  task automatic sel(input logic [3:0] q);
    @(posedge i_clk);
    o_strobe <= 1'b1;
    o_addr <= q;
    o_wen_n <= 1'b1;
    @(posedge i_clk);
    o_strobe <= 1'b0;
    o_wdata <= FILL;
    o_wen_n <= 1'b0;
    @(posedge i_clk);
    o_wen_n <= 1'b1;
    o_wdata <= ~FILL;
  endtask : sel

  task automatic put(input logic [DATA_W-1:0] w);
    @(posedge i_clk);
    o_wdata <= w;
    o_wen_n <= 1'b0;
  endtask : put

  // Released bus shows the inverse of the last word
  task automatic idle;
    @(posedge i_clk);
    o_wen_n <= 1'b1;
    o_wdata <= ~o_wdata;
  endtask : idle
endmodule : pmq_host

// File: bench/packet_mode_queue_switch_ready_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module packet_mode_queue_switch_ready_test;
  import pmq_pkg::*;
  localparam logic [DATA_W-1:0] FILL = 36'h0_0000_0000;
  logic i_clk, i_rst_n, i_write_queue_select_strobe, i_write_enable_n, o_full_flag_n;
  logic [3:0] i_write_queue_address, i_read_queue_address;
  logic [DATA_W-1:0] i_wdata, o_rdata, mon_word;
  logic i_read_queue_select_strobe, i_read_enable_n, o_rx_start_marker, o_rx_end_marker;
  logic o_output_valid_n, o_packet_ready_n, o_flag_bus_sector;
  logic i_ce, i_packet_mode_select, i_flag_bus_style, i_output_drive_enable_n;
  logic [3:0] i_axi_wstrb;
  int len2;
  logic [7:0] o_packet_ready_bus;
  logic i_axi_awvalid, o_axi_awready, i_axi_wvalid, o_axi_wready, o_axi_bvalid, i_axi_bready;
  logic i_axi_arvalid, o_axi_arready, o_axi_rvalid, i_axi_rready;
  logic [31:0] i_axi_awaddr, i_axi_wdata, i_axi_araddr, o_axi_rdata;
  logic [1:0] o_axi_bresp, o_axi_rresp;
  logic [DATA_W-1:0] exp_q[$];
  int checked = 0;
  int mismatches = 0;
  int cycles = 0;

  pmq_switch dut (.i_clk, .i_rst_n, .i_ce, .i_packet_mode_select,
    .i_flag_bus_style, .i_write_queue_select_strobe, .i_write_queue_address,
    .i_write_enable_n, .i_wdata, .o_full_flag_n, .i_read_queue_select_strobe,
    .i_read_queue_address, .i_read_enable_n, .i_output_drive_enable_n, .o_rdata,
    .o_rx_start_marker, .o_rx_end_marker, .o_output_valid_n, .o_packet_ready_n,
    .o_packet_ready_bus, .o_flag_bus_sector, .i_axi_awvalid, .o_axi_awready, .i_axi_awaddr,
    .i_axi_wvalid, .o_axi_wready, .i_axi_wdata, .i_axi_wstrb, .o_axi_bvalid,
    .i_axi_bready, .o_axi_bresp, .i_axi_arvalid, .o_axi_arready, .i_axi_araddr,
    .o_axi_rvalid, .i_axi_rready, .o_axi_rdata, .o_axi_rresp);

  pmq_host host (.i_clk(i_clk), .o_strobe(i_write_queue_select_strobe),
    .o_addr(i_write_queue_address), .o_wen_n(i_write_enable_n), .o_wdata(i_wdata));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and cycle limit
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end

  // Read monitor: every taken word except fillers against the oldest note
  always @(posedge i_clk) begin
    if (i_rst_n && o_output_valid_n === 1'b0 && i_read_enable_n === 1'b0 && o_rdata !== FILL
        && (i_read_queue_select_strobe === 1'b0 || i_output_drive_enable_n === 1'b0)) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("mismatch at %0t: unexpected word", $time);
      end else begin
        mon_word = exp_q.pop_front();
        `CHK(o_rdata, mon_word)
        `CHK({o_rx_end_marker, o_rx_start_marker}, mon_word[35:34])
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Bus write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] r);
    @(posedge i_clk);
    i_axi_awvalid <= 1'b1;
    i_axi_awaddr <= a;
    i_axi_wvalid <= 1'b1;
    i_axi_wdata <= d;
    i_axi_wstrb <= s;
    i_axi_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_axi_awvalid && o_axi_awready) i_axi_awvalid <= 1'b0;
      if (i_axi_wvalid && o_axi_wready) i_axi_wvalid <= 1'b0;
    end while (o_axi_bvalid !== 1'b1);
    i_axi_bready <= 1'b0;
    `CHK(o_axi_bresp, r)
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge i_clk);
    i_axi_arvalid <= 1'b1;
    i_axi_araddr <= a;
    i_axi_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_axi_arvalid && o_axi_arready) i_axi_arvalid <= 1'b0;
    end while (o_axi_rvalid !== 1'b1);
    i_axi_rready <= 1'b0;
    `CHK(o_axi_rdata, d)
    `CHK(o_axi_rresp, r)
  endtask : axi_rd

  // One random word with markers, noted for the monitor
  task automatic wr(input logic e, input logic s);
    logic [DATA_W-1:0] w;
    w = {e, s, 2'b00, $urandom() | 32'h1};
    host.put(w);
    exp_q.push_back(w);
  endtask : wr

  task automatic pkt(input int n, input logic dup);
    for (int i = 0; i < n; i++) begin
      wr(i == n - 1, i == 0 || (dup && i == 1));
    end
    host.idle();
  endtask : pkt

  task automatic rsel(input logic [3:0] q);
    @(posedge i_clk);
    i_read_queue_select_strobe <= 1'b1;
    i_read_queue_address <= q;
    i_read_enable_n <= 1'b1;
    i_output_drive_enable_n <= 1'b1;
    @(posedge i_clk);
    i_read_queue_select_strobe <= 1'b0;
    i_output_drive_enable_n <= 1'b0;
  endtask : rsel

  task automatic drain(input int left);
    int n;
    n = 0;
    i_read_enable_n <= 1'b0;
    while (exp_q.size() > left && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    `CHK(exp_q.size(), left)
    repeat (4) @(posedge i_clk);
    `CHK(o_packet_ready_n, 1'b1)
    i_read_enable_n <= 1'b1;
  endtask : drain

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    {i_read_queue_select_strobe, i_read_queue_address, i_read_enable_n} = 6'h01;
    {i_axi_awvalid, i_axi_wvalid, i_axi_bready, i_axi_arvalid, i_axi_rready} = 5'h00;
    {i_axi_awaddr, i_axi_wdata, i_axi_araddr} = 96'h0;
    {i_ce, i_packet_mode_select, i_flag_bus_style, i_output_drive_enable_n} = 4'hC;
    i_axi_wstrb = 4'hF;
    void'($urandom(65));
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    `CHK(o_packet_ready_n, 1'b1)
    host.sel(4'h1);
    wr(1'b0, 1'b1);
    wr(1'b0, 1'b0);
    wr(1'b0, 1'b0);
    host.idle();
    rsel(4'h1);
    i_read_enable_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    `CHK(o_output_valid_n, 1'b1)
    `CHK(o_packet_ready_n, 1'b1)
    i_read_enable_n <= 1'b1;
    wr(1'b1, 1'b0);
    host.idle();
    @(negedge i_clk);
    `CHK(o_packet_ready_n, 1'b0)
    // Only packet: its start word out clears ready, valid stays
    repeat (4) @(negedge i_clk);
    `CHK(o_packet_ready_n, 1'b1)
    `CHK(o_output_valid_n, 1'b0)
    axi_rd({28'h0, REG_STATUS}, 32'h0000_0111, RESP_OKAY);
    drain(0);
    // Packets in queues 2 and 3, status seen from queue 1
    host.sel(4'h2);
    len2 = $urandom_range(6, 4);
    pkt(len2, 1'b1);
    host.sel(4'h3);
    pkt($urandom_range(6, 4), 1'b0);
    repeat (4) @(negedge i_clk);
    `CHK(o_packet_ready_n, 1'b1)
    `CHK(o_packet_ready_bus, 8'hF3)
    axi_rd({28'h0, REG_READY}, 32'h0000_000C, RESP_OKAY);
    axi_wr({28'h0, REG_CTRL}, 32'h0000_0001, 4'hF, RESP_OKAY);
    repeat (2) @(negedge i_clk);
    `CHK(o_packet_ready_bus, 8'hFF)
    axi_rd({28'h0, REG_CTRL}, 32'h0000_0001, RESP_OKAY);
    axi_wr({28'h0, REG_CTRL}, 32'h0000_0000, 4'hF, RESP_OKAY);
    // Sector bit sits in byte lane 0, so a lane 1 write leaves it clear
    axi_wr({28'h0, REG_CTRL}, 32'h0000_0001, 4'h2, RESP_OKAY);
    axi_rd({28'h0, REG_CTRL}, 32'h0000_0000, RESP_OKAY);
    axi_rd(32'h0000_000C, 32'h0000_0000, RESP_SLVERR);
    axi_wr(32'h0000_000C, 32'h0000_0005, 4'hF, RESP_SLVERR);
    rsel(4'h2);
    drain(exp_q.size() - len2);
    rsel(4'h3);
    drain(0);
    // Fill queue 5, then switch away and back
    host.sel(4'h5);
    for (int n = 0; n < 40 && o_full_flag_n; n++) host.put(36'h0_0000_0001);
    host.idle();
    @(negedge i_clk);
    `CHK(o_full_flag_n, 1'b0)
    host.sel(4'h6);
    @(negedge i_clk);
    `CHK(o_full_flag_n, 1'b1)
    host.sel(4'h5);
    @(negedge i_clk);
    `CHK(o_full_flag_n, 1'b0)
    // Frozen clock enable: a queue change request goes unseen
    @(posedge i_clk);
    i_ce <= 1'b0;
    host.sel(4'h6);
    @(negedge i_clk);
    `CHK(o_full_flag_n, 1'b0)
    summarize();
  end
endmodule : packet_mode_queue_switch_ready_test
